// ---- core/apc_regs.sv ----
// pair A control register bank with three-wire serial control port
// Functional notes
// [RQ1] pll power bit 0 external clock, 1 pll; role bit 0 slave, 1 master.
// [RQ2] four-bit pll reference select resets to 0110.
// [RQ3] read enable bit resets 0; readback only when set to 1.
// [RQ4] per-channel input type: 0 single-ended (reset), 1 fully differential.
// [RQ5] three-bit amp gain field resets to 110.
// [RQ6] first highpass enable resets off; cutoff field resets 00; host should enable.
// [RQ7] left and right sensitivity trims reset to 4H.
// [RQ8] interface format resets 11; slot format resets 00.
// [RQ9] sample rate select resets to 1111.
// [RQ10] second highpass enable 1 uses coefficients, 0 passes unchanged.
// [RQ11] lowpass enable 1 uses coefficients, 0 (reset) bypasses.
// [RQ12] master clock out low when disabled, else selected frequency.
// [RQ13] external input clock ratio field resets to 00.
// [RQ14] init cycle length field resets 00, meaning 1059 sample periods.
// [RQ15] bit clock output ratio field resets 00.
// [RQ16] left and right volume registers reset to 91H.
// [RQ17] volume link 1 (reset): left value drives both; right register untouched.
// [RQ18] volume ramp time bit resets to 1.
// [RQ19] level control enable and four-channel link off; eq disable 0; threshold 00.
// [RQ20] recovery wait, fast speed, fast attenuation all reset to zero codes.
// [RQ21] recovery reference resets to E1H.
// [RQ22] left one delay: enabled applies amount steps, disabled gives no delay.
// [RQ23] channel power rising starts init cycle before data is declared ready.
// [RQ24] power-down pin low returns every register to its reset value.
// [RQ25] host writes zero into fixed-zero positions.
// [RQ26] fixed-zero positions read zero and ignore writes.
module apc_regs
  import apc_pkg::*;
#(
  parameter logic [1:0]        CHIP_ADDR = 2'b00,
  parameter int unsigned       INIT_LEN0 = apc_pkg::INIT_FS_0,
  parameter int unsigned       INIT_LEN1 = apc_pkg::INIT_FS_1,
  parameter int unsigned       INIT_LEN2 = apc_pkg::INIT_FS_2,
  parameter int unsigned       INIT_LEN3 = apc_pkg::INIT_FS_3
) (
  input  wire logic            ref_clk,
  input  wire logic            rst,
  input  wire logic            power_down_pin_n,
  input  wire logic            ser_csn,
  input  wire logic            ser_cclk,
  input  wire logic            ser_data_in,
  output logic                 ser_data_out,
  output logic                 ser_data_oe_n,
  input  wire logic            left_channel_power,
  input  wire logic            fs_tick,
  input  wire logic [3:0]      clock_out_sources,
  output logic                 master_clock_out,
  output logic                 left_adc_ready,
  output logic                 pll_power_bit,
  output logic                 master_role,
  output logic [3:0]           pll_reference_select,
  output logic                 left_input_type,
  output logic                 right_input_type,
  output logic [2:0]           amp_gain_a,
  output logic                 first_highpass_enable,
  output logic [1:0]           highpass_cutoff,
  output logic [3:0]           left_sensitivity_trim,
  output logic [3:0]           right_sensitivity_trim,
  output logic [1:0]           interface_format,
  output logic [1:0]           slot_format,
  output logic [1:0]           bitclock_out_ratio,
  output logic [3:0]           sample_rate_select,
  output logic                 second_highpass_active,
  output logic                 lowpass_active,
  output logic [1:0]           ext_input_clock_ratio,
  output logic [1:0]           init_cycle_length,
  output logic [7:0]           left_volume_eff,
  output logic [7:0]           right_volume_eff,
  output logic                 volume_ramp_time,
  output logic [1:0]           recovery_wait,
  output logic                 fast_recovery_atten,
  output logic [1:0]           fast_recovery_speed,
  output logic                 level_control_enable,
  output logic                 four_channel_link,
  output logic                 level_eq_disable,
  output logic [2:0]           recovery_gain_step,
  output logic [1:0]           limiter_threshold,
  output logic [7:0]           recovery_reference,
  output logic [6:0]           left_one_delay_steps
);
  import apc_pkg::*;

  function automatic logic [7:0] wr_mask(input logic [4:0] a);
    case (a)
      ADDR_PLL:  wr_mask = MASK_PLL;
      ADDR_GAIN: wr_mask = MASK_GAIN;
      ADDR_LTRM: wr_mask = MASK_LTRM;
      ADDR_CLKO: wr_mask = MASK_CLKO;
      ADDR_TIMR: wr_mask = MASK_TIMR;
      ADDR_DLY:  wr_mask = MASK_DLY;
      ADDR_RTRM, ADDR_FILT, ADDR_LVOL, ADDR_RVOL,
      ADDR_LCM,  ADDR_LCR:  wr_mask = MASK_FULL;
      default:   wr_mask = RST_ZERO;
    endcase
  endfunction

  function automatic logic [7:0] rst_val(input logic [4:0] a);
    case (a)
      ADDR_PLL:  rst_val = RST_PLL;   // [RQ1] [RQ2] [RQ3]
      ADDR_GAIN: rst_val = RST_GAIN;  // [RQ4] [RQ5] [RQ6]
      ADDR_LTRM: rst_val = RST_LTRM;  // [RQ7] [RQ8]
      ADDR_RTRM: rst_val = RST_RTRM;  // [RQ7] [RQ8] [RQ15]
      ADDR_FILT: rst_val = RST_FILT;  // [RQ6] [RQ9] [RQ11]
      ADDR_LVOL: rst_val = RST_VOL;   // [RQ16]
      ADDR_RVOL: rst_val = RST_VOL;   // [RQ16]
      ADDR_TIMR: rst_val = RST_TIMR;  // [RQ17] [RQ18] [RQ20]
      ADDR_LCR:  rst_val = RST_LCR;   // [RQ21]
      default:   rst_val = RST_ZERO;  // [RQ12] [RQ13] [RQ14] [RQ19] [RQ22]
    endcase
  endfunction

  // pin synchronisers: stage 1 only feeds stage 2
  logic       csn_s1_q, csn_s2_q;
  logic       cclk_s1_q, cclk_s2_q, cclk_s3_q;
  logic       sdi_s1_q, sdi_s2_q;
  logic       pdn_s1_q, pdn_s2_q;
  logic [3:0] cko_s1_q, cko_s2_q;

  always_ff @(posedge ref_clk) begin
    csn_s1_q  <= ser_csn;
    csn_s2_q  <= csn_s1_q;
    cclk_s1_q <= ser_cclk;
    cclk_s2_q <= cclk_s1_q;
    cclk_s3_q <= cclk_s2_q;
    sdi_s1_q  <= ser_data_in;
    sdi_s2_q  <= sdi_s1_q;
    pdn_s1_q  <= power_down_pin_n;
    pdn_s2_q  <= pdn_s1_q;
    cko_s1_q  <= clock_out_sources;
    cko_s2_q  <= cko_s1_q;
  end

  wire reg_clear = rst | ~pdn_s2_q;  // [RQ24]
  wire cclk_rise = cclk_s2_q & ~cclk_s3_q;
  wire cclk_fall = ~cclk_s2_q & cclk_s3_q;

  // serial frame: chip[1:0], write flag, address[4:0], data[7:0], msb first
  apc_ser_e   ser_q, ser_d;
  logic [6:0] shift_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] hdr_q;
  logic [7:0] rd_q;
  logic       dout_q;
  logic       oe_n_q;
  logic [7:0] regs_q [0:15];

  wire [7:0] word_now  = {shift_q, sdi_s2_q};
  wire       hdr_end   = cclk_rise && (bit_cnt_q == 4'(HDR_BITS - 1));
  wire       frame_end = cclk_rise && (bit_cnt_q == 4'(FRAME_BITS - 1));
  wire       chip_ok   = (hdr_q[7:6] == CHIP_ADDR);
  wire       is_write  = hdr_q[5];
  wire [4:0] acc_addr  = hdr_q[4:0];
  wire       read_en   = regs_q[ADDR_PLL[3:0]][POS_READ_EN];
  wire [4:0] hdr_addr  = word_now[4:0];
  wire       wr_fire   = (ser_q == SER_DATA) && frame_end && chip_ok && is_write;
  // masked readback keeps fixed-zero and unmapped positions at zero
  wire [7:0] rd_word   = regs_q[hdr_addr[3:0]] & wr_mask(hdr_addr);  // [RQ26]
  wire       rd_start  = hdr_end && (word_now[7:6] == CHIP_ADDR) && !word_now[5]
                         && read_en;  // [RQ3]

  always_comb begin
    ser_d = ser_q;
    case (ser_q)
      SER_IDLE: if (!csn_s2_q) ser_d = SER_HDR;
      SER_HDR:  if (hdr_end) ser_d = SER_DATA;
      SER_DATA: if (frame_end) ser_d = SER_IDLE;
      default:  ser_d = SER_IDLE;
    endcase
    if (csn_s2_q) ser_d = SER_IDLE;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ser_q     <= SER_IDLE;
      shift_q   <= '0;
      bit_cnt_q <= '0;
      hdr_q     <= '0;
    end else begin
      ser_q <= ser_d;
      if (csn_s2_q) begin
        bit_cnt_q <= '0;
      end else if (cclk_rise) begin
        shift_q   <= word_now[6:0];
        bit_cnt_q <= bit_cnt_q + 4'd1;
        if (hdr_end) hdr_q <= word_now;
      end
    end
  end

  // readback drives on falling edges so the host samples on rising ones
  always_ff @(posedge ref_clk) begin
    if (rst || csn_s2_q) begin
      rd_q   <= '0;
      dout_q <= 1'b0;
      oe_n_q <= 1'b1;
    end else if (rd_start) begin
      rd_q   <= rd_word;
    end else if (cclk_fall && ser_q == SER_DATA && !is_write && chip_ok && read_en) begin
      dout_q <= rd_q[7];
      rd_q   <= {rd_q[6:0], 1'b0};
      oe_n_q <= 1'b0;
    end
  end

  assign ser_data_out  = dout_q;
  assign ser_data_oe_n = oe_n_q;

  // register array; writes are masked so fixed-zero spots stay zero whatever the far party sends
  always_ff @(posedge ref_clk) begin
    if (reg_clear) begin
      for (int i = 0; i < 16; i++) regs_q[i] <= rst_val(5'(i));  // [RQ24]
    end else if (wr_fire && |wr_mask(acc_addr)) begin
      regs_q[acc_addr[3:0]] <= word_now & wr_mask(acc_addr);  // [RQ26] [RQ25]
    end
  end

  assign pll_power_bit         = regs_q[ADDR_PLL[3:0]][POS_PLL_PWR];  // [RQ1]
  assign master_role           = regs_q[ADDR_PLL[3:0]][POS_ROLE];  // [RQ1]
  assign pll_reference_select  = regs_q[ADDR_PLL[3:0]][POS_PLL_REF +: 4];  // [RQ2]
  assign left_input_type       = regs_q[ADDR_GAIN[3:0]][POS_LTYPE];  // [RQ4]
  assign right_input_type      = regs_q[ADDR_GAIN[3:0]][POS_RTYPE];  // [RQ4]
  assign amp_gain_a            = regs_q[ADDR_GAIN[3:0]][POS_AMP_GAIN +: 3];  // [RQ5]
  assign first_highpass_enable = regs_q[ADDR_GAIN[3:0]][POS_HPF1_EN];  // [RQ6]
  assign highpass_cutoff       = regs_q[ADDR_FILT[3:0]][POS_HPF_CUT +: 2];  // [RQ6]
  assign left_sensitivity_trim = regs_q[ADDR_LTRM[3:0]][POS_TRIM +: 4];  // [RQ7]
  assign right_sensitivity_trim = regs_q[ADDR_RTRM[3:0]][POS_TRIM +: 4];  // [RQ7]
  assign interface_format      = regs_q[ADDR_LTRM[3:0]][POS_IFMT +: 2];  // [RQ8]
  assign slot_format           = regs_q[ADDR_RTRM[3:0]][POS_SLOT +: 2];  // [RQ8]
  assign bitclock_out_ratio    = regs_q[ADDR_RTRM[3:0]][POS_BCK +: 2];  // [RQ15]
  assign sample_rate_select    = regs_q[ADDR_FILT[3:0]][POS_FS +: 4];  // [RQ9]
  assign second_highpass_active = regs_q[ADDR_FILT[3:0]][POS_HPF2_EN];  // [RQ10]
  assign lowpass_active        = regs_q[ADDR_FILT[3:0]][POS_LPF_EN];  // [RQ11]
  assign ext_input_clock_ratio = regs_q[ADDR_CLKO[3:0]][POS_EXT_RAT +: 2];  // [RQ13]
  assign init_cycle_length     = regs_q[ADDR_CLKO[3:0]][POS_INIT_LEN +: 2];  // [RQ14]
  assign left_volume_eff       = regs_q[ADDR_LVOL[3:0]];  // [RQ16]
  assign volume_ramp_time      = regs_q[ADDR_TIMR[3:0]][POS_RAMP];  // [RQ18]
  assign recovery_wait         = regs_q[ADDR_TIMR[3:0]][POS_WAIT +: 2];  // [RQ20]
  assign fast_recovery_atten   = regs_q[ADDR_TIMR[3:0]][POS_FATT];  // [RQ20]
  assign fast_recovery_speed   = regs_q[ADDR_TIMR[3:0]][POS_FSPD +: 2];  // [RQ20]
  assign level_control_enable  = regs_q[ADDR_LCM[3:0]][POS_LC_EN];  // [RQ19]
  assign four_channel_link     = regs_q[ADDR_LCM[3:0]][POS_LC4];  // [RQ19]
  assign level_eq_disable      = regs_q[ADDR_LCM[3:0]][POS_EQ_DIS];  // [RQ19]
  assign recovery_gain_step    = regs_q[ADDR_LCM[3:0]][POS_RGAIN +: 3];
  assign limiter_threshold     = regs_q[ADDR_LCM[3:0]][POS_LIM_TH +: 2];  // [RQ19]
  assign recovery_reference    = regs_q[ADDR_LCR[3:0]];  // [RQ21]

  // derived outputs, each from its own flop
  wire       vol_link  = regs_q[ADDR_TIMR[3:0]][POS_VLINK];
  wire       cko_en    = regs_q[ADDR_CLKO[3:0]][POS_CKO_EN];
  wire [1:0] cko_sel   = regs_q[ADDR_CLKO[3:0]][POS_CKO_FREQ +: 2];
  wire       dly_en    = regs_q[ADDR_DLY[3:0]][POS_DLY_EN];
  wire [5:0] dly_amt   = regs_q[ADDR_DLY[3:0]][POS_DLY_AMT +: 6];
  // right register keeps its own value; only the applied level follows left
  wire [7:0] rvol_d    = vol_link ? regs_q[ADDR_LVOL[3:0]]
                                  : regs_q[ADDR_RVOL[3:0]];  // [RQ17]
  // code 00H already means one step, so steps are amount plus one
  wire [6:0] dly_d     = dly_en ? ({1'b0, dly_amt} + 7'd1) : 7'd0;  // [RQ22]
  wire       mclk_d    = cko_en & cko_s2_q[cko_sel];  // [RQ12]

  logic [7:0] rvol_q;
  logic [6:0] dly_q;
  logic       mclk_q;

  always_ff @(posedge ref_clk) begin
    if (reg_clear) begin
      rvol_q <= RST_VOL;
      dly_q  <= '0;
      mclk_q <= 1'b0;
    end else begin
      rvol_q <= rvol_d;
      dly_q  <= dly_d;
      mclk_q <= mclk_d;
    end
  end

  assign right_volume_eff     = rvol_q;
  assign left_one_delay_steps = dly_q;
  assign master_clock_out     = mclk_q;

  // initialization cycle after the left channel powers up
  function automatic logic [INIT_CW-1:0] init_len(input logic [1:0] code);
    case (code)
      2'b00:   init_len = INIT_CW'(INIT_LEN0);
      2'b01:   init_len = INIT_CW'(INIT_LEN1);
      2'b10:   init_len = INIT_CW'(INIT_LEN2);
      default: init_len = INIT_CW'(INIT_LEN3);
    endcase
  endfunction

  apc_init_e          ini_q, ini_d;
  logic               pwr_prev_q;
  logic [INIT_CW-1:0] ini_cnt_q;
  logic               ready_q;

  wire pwr_rise = left_channel_power & ~pwr_prev_q;
  wire cnt_last = fs_tick && (ini_cnt_q == init_len(init_cycle_length) - INIT_CW'(1));

  always_comb begin
    ini_d = ini_q;
    case (ini_q)
      INI_OFF:  if (pwr_rise) ini_d = INI_RUN;  // [RQ23]
      INI_RUN:  if (cnt_last) ini_d = INI_DONE;  // [RQ23]
      INI_DONE: ini_d = INI_DONE;
      default:  ini_d = INI_OFF;
    endcase
    if (!left_channel_power) ini_d = INI_OFF;
  end

  always_ff @(posedge ref_clk) begin
    if (reg_clear) begin
      ini_q      <= INI_OFF;
      pwr_prev_q <= 1'b0;
      ini_cnt_q  <= '0;
      ready_q    <= 1'b0;
    end else begin
      ini_q      <= ini_d;
      pwr_prev_q <= left_channel_power;
      ready_q    <= (ini_d == INI_DONE);
      if (ini_q != INI_RUN) ini_cnt_q <= '0;
      else if (fs_tick) ini_cnt_q <= ini_cnt_q + INIT_CW'(1);
    end
  end

  assign left_adc_ready = ready_q;
endmodule

// ---- core/apc_pkg.sv ----
// constants for the pair A control register bank
package apc_pkg;
  localparam int unsigned AW         = 5;
  localparam int unsigned DW         = 8;
  localparam int unsigned FRAME_BITS = 16;
  localparam int unsigned HDR_BITS   = 8;

  // register offsets
  localparam logic [4:0] ADDR_PLL  = 5'h01;
  localparam logic [4:0] ADDR_GAIN = 5'h02;
  localparam logic [4:0] ADDR_LTRM = 5'h03;
  localparam logic [4:0] ADDR_RTRM = 5'h04;
  localparam logic [4:0] ADDR_FILT = 5'h05;
  localparam logic [4:0] ADDR_CLKO = 5'h06;
  localparam logic [4:0] ADDR_LVOL = 5'h07;
  localparam logic [4:0] ADDR_RVOL = 5'h08;
  localparam logic [4:0] ADDR_TIMR = 5'h09;
  localparam logic [4:0] ADDR_LCM  = 5'h0A;
  localparam logic [4:0] ADDR_LCR  = 5'h0B;
  localparam logic [4:0] ADDR_DLY  = 5'h0C;

  // writable bit masks, fixed-zero positions cleared
  localparam logic [7:0] MASK_PLL  = 8'hBF;
  localparam logic [7:0] MASK_GAIN = 8'hF3;
  localparam logic [7:0] MASK_LTRM = 8'hCF;
  localparam logic [7:0] MASK_CLKO = 8'hF7;
  localparam logic [7:0] MASK_TIMR = 8'hBF;
  localparam logic [7:0] MASK_DLY  = 8'hBF;
  localparam logic [7:0] MASK_FULL = 8'hFF;

  // reset values
  localparam logic [7:0] RST_PLL  = 8'h18;
  localparam logic [7:0] RST_GAIN = 8'h60;
  localparam logic [7:0] RST_LTRM = 8'hC4;
  localparam logic [7:0] RST_RTRM = 8'h04;
  localparam logic [7:0] RST_FILT = 8'h0F;
  localparam logic [7:0] RST_VOL  = 8'h91;
  localparam logic [7:0] RST_TIMR = 8'h84;
  localparam logic [7:0] RST_LCR  = 8'hE1;
  localparam logic [7:0] RST_ZERO = 8'h00;

  // field positions (lsb)
  localparam int unsigned POS_PLL_PWR  = 0;
  localparam int unsigned POS_ROLE     = 1;
  localparam int unsigned POS_PLL_REF  = 2;
  localparam int unsigned POS_READ_EN  = 7;
  localparam int unsigned POS_LTYPE    = 0;
  localparam int unsigned POS_RTYPE    = 1;
  localparam int unsigned POS_AMP_GAIN = 4;
  localparam int unsigned POS_HPF1_EN  = 7;
  localparam int unsigned POS_TRIM     = 0;
  localparam int unsigned POS_IFMT     = 6;
  localparam int unsigned POS_BCK      = 4;
  localparam int unsigned POS_SLOT     = 6;
  localparam int unsigned POS_FS       = 0;
  localparam int unsigned POS_HPF2_EN  = 4;
  localparam int unsigned POS_LPF_EN   = 5;
  localparam int unsigned POS_HPF_CUT  = 6;
  localparam int unsigned POS_CKO_FREQ = 0;
  localparam int unsigned POS_CKO_EN   = 2;
  localparam int unsigned POS_EXT_RAT  = 4;
  localparam int unsigned POS_INIT_LEN = 6;
  localparam int unsigned POS_WAIT     = 0;
  localparam int unsigned POS_RAMP     = 2;
  localparam int unsigned POS_FATT     = 3;
  localparam int unsigned POS_FSPD     = 4;
  localparam int unsigned POS_VLINK    = 7;
  localparam int unsigned POS_LIM_TH   = 0;
  localparam int unsigned POS_RGAIN    = 2;
  localparam int unsigned POS_EQ_DIS   = 5;
  localparam int unsigned POS_LC4      = 6;
  localparam int unsigned POS_LC_EN    = 7;
  localparam int unsigned POS_DLY_AMT  = 0;
  localparam int unsigned POS_DLY_EN   = 7;

  // initialization cycle lengths in sample periods
  localparam int unsigned INIT_FS_0 = 1059;
  localparam int unsigned INIT_FS_1 = 267;
  localparam int unsigned INIT_FS_2 = 531;
  localparam int unsigned INIT_FS_3 = 2115;
  localparam int unsigned INIT_CW   = 12;

  typedef enum logic [2:0] {
    SER_IDLE = 3'b001,
    SER_HDR  = 3'b010,
    SER_DATA = 3'b100
  } apc_ser_e;

  typedef enum logic [2:0] {
    INI_OFF  = 3'b001,
    INI_RUN  = 3'b010,
    INI_DONE = 3'b100
  } apc_init_e;
endpackage

// ---- sim/apc_regs_props.sv ----
// concurrent checks on the pair A register bank ports
module apc_regs_props (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       power_down_pin_n,
  input wire logic       ser_csn,
  input wire logic       ser_cclk,
  input wire logic       ser_data_out,
  input wire logic       ser_data_oe_n,
  input wire logic       left_channel_power,
  input wire logic       fs_tick,
  input wire logic [3:0] clock_out_sources,
  input wire logic       master_clock_out,
  input wire logic       left_adc_ready,
  input wire logic [3:0] pll_reference_select,
  input wire logic [2:0] amp_gain_a,
  input wire logic [3:0] sample_rate_select,
  input wire logic [7:0] left_volume_eff,
  input wire logic [7:0] right_volume_eff,
  input wire logic [7:0] recovery_reference,
  input wire logic [6:0] left_one_delay_steps
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  property p_rst_vals;
    $fell(rst) |-> pll_reference_select == 4'h6 && amp_gain_a == 3'h6
      && sample_rate_select == 4'hF && recovery_reference == 8'hE1;
  endproperty
  a_rst_vals: assert property (p_rst_vals)
    else $error("field not at reset value after reset");

  property p_rst_vol;
    $fell(rst) |-> left_volume_eff == 8'h91 && right_volume_eff == 8'h91;
  endproperty
  a_rst_vol: assert property (p_rst_vol)
    else $error("volume not at reset value after reset");

  // pin is synchronised, so allow its two flops before the clear shows
  property p_pdn_vals;
    (!power_down_pin_n) [*5] |-> left_volume_eff == 8'h91 && recovery_reference == 8'hE1
      && left_one_delay_steps == 7'h00 && amp_gain_a == 3'h6;
  endproperty
  a_pdn_vals: assert property (p_pdn_vals)
    else $error("registers not cleared while power-down pin low");

  property p_ready_clr;
    !left_channel_power |=> !left_adc_ready;
  endproperty
  a_ready_clr: assert property (p_ready_clr)
    else $error("ready high while channel powered down");

  property p_ready_rise;
    $rose(left_adc_ready) |-> $past(left_channel_power, 2)
      && ($past(fs_tick, 1) || $past(fs_tick, 2) || $past(fs_tick, 3));
  endproperty
  a_ready_rise: assert property (p_ready_rise)
    else $error("ready rose without a closing sample tick");

  property p_dly_rng;
    left_one_delay_steps <= 7'd64;
  endproperty
  a_dly_rng: assert property (p_dly_rng)
    else $error("delay steps beyond 64");

  property p_oe_idle;
    ser_csn [*5] |-> ser_data_oe_n;
  endproperty
  a_oe_idle: assert property (p_oe_idle)
    else $error("data pin driven with chip select high");

  property p_dout_hold;
    ser_cclk [*6] ##0 !ser_data_oe_n |-> $stable(ser_data_out);
  endproperty
  a_dout_hold: assert property (p_dout_hold)
    else $error("readback bit changed while serial clock high");

  property p_mclk_src;
    master_clock_out |-> ($past(clock_out_sources, 2) | $past(clock_out_sources, 3)
      | $past(clock_out_sources, 4)) != 4'h0;
  endproperty
  a_mclk_src: assert property (p_mclk_src)
    else $error("clock output high with no source high");
endmodule

bind apc_regs apc_regs_props u_props (
  .ref_clk, .rst, .power_down_pin_n, .ser_csn, .ser_cclk, .ser_data_out, .ser_data_oe_n,
  .left_channel_power, .fs_tick, .clock_out_sources, .master_clock_out, .left_adc_ready,
  .pll_reference_select, .amp_gain_a, .sample_rate_select, .left_volume_eff,
  .right_volume_eff, .recovery_reference, .left_one_delay_steps
);

// ---- sim/apc_host_model.sv ----
// host side of the three-wire serial control port
module apc_host_model (
  input  wire logic ref_clk,
  output logic      ser_csn,
  output logic      ser_cclk,
  output logic      host_data,
  input  wire logic wire_data,
  input  wire logic ser_data_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  int half = 6;

  initial begin
    ser_csn = 1'b1;
    ser_cclk = 1'b1;
    host_data = 1'b0;
  end

  // serial clock stands high between frames; half must stay >= 4 for readback
  task automatic xfer(input logic [15:0] fr, output logic [7:0] rd, output logic drove);
    rd = 8'h00;
    drove = 1'b0;
    @(posedge ref_clk);
    #1 ser_csn = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      repeat (half) @(posedge ref_clk);
      #1 ser_cclk = 1'b0;
      host_data = fr[i];
      repeat (half) @(posedge ref_clk);
      if (i < 8) begin
        rd[i] = wire_data;
        drove = drove | ~ser_data_oe_n;
      end
      #1 ser_cclk = 1'b1;
    end
    repeat (half) @(posedge ref_clk);
    #1 ser_csn = 1'b1;
    // released line must not keep showing the last bit
    host_data = ~host_data;
    repeat (4) @(posedge ref_clk);
  endtask
endmodule

// ---- sim/adc_pair_a_control_registers_tb.sv ----
// self-checking bench for the pair A control register bank
module adc_pair_a_control_registers_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       ref_clk, rst, pdn_n, csn, cclk, hd, pwr, fs_tick;
  logic [3:0] src;
  logic [1:0] sel;
  logic [7:0] sh [1:12];
  logic [7:0] rv [1:12] = '{8'h18, 8'h60, 8'hC4, 8'h04, 8'h0F, 8'h00,
                            8'h91, 8'h91, 8'h84, 8'h00, 8'hE1, 8'h00};
  logic [7:0] mk [1:12] = '{8'hBF, 8'hF3, 8'hCF, 8'hFF, 8'hFF, 8'hF7,
                            8'hFF, 8'hFF, 8'hBF, 8'hFF, 8'hFF, 8'hBF};
  int         ilen [4] = '{5, 3, 4, 6};
  int         n_mismatch, samples_checked, mclk_hi, cnt;
  wire        sdo, oe_n;
  wire        sdw = oe_n ? hd : sdo;

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    #1;
    cnt = cnt + 1;
    fs_tick = (cnt % 8 == 0);
    src = cnt[1] ? 4'h1 << sel : 4'h0;
    if (u_dut.master_clock_out === 1'b1) mclk_hi = mclk_hi + 1;
  end

  apc_regs #(.INIT_LEN0(5), .INIT_LEN1(3), .INIT_LEN2(4), .INIT_LEN3(6)) u_dut (
    .ref_clk(ref_clk), .rst(rst), .power_down_pin_n(pdn_n), .ser_csn(csn),
    .ser_cclk(cclk), .ser_data_in(sdw), .ser_data_out(sdo), .ser_data_oe_n(oe_n),
    .left_channel_power(pwr), .fs_tick(fs_tick), .clock_out_sources(src),
    .master_clock_out(), .left_adc_ready(), .pll_power_bit(), .master_role(),
    .pll_reference_select(), .left_input_type(), .right_input_type(), .amp_gain_a(),
    .first_highpass_enable(), .highpass_cutoff(), .left_sensitivity_trim(),
    .right_sensitivity_trim(), .interface_format(), .slot_format(),
    .bitclock_out_ratio(), .sample_rate_select(), .second_highpass_active(),
    .lowpass_active(), .ext_input_clock_ratio(), .init_cycle_length(),
    .left_volume_eff(), .right_volume_eff(), .volume_ramp_time(), .recovery_wait(),
    .fast_recovery_atten(), .fast_recovery_speed(), .level_control_enable(),
    .four_channel_link(), .level_eq_disable(), .recovery_gain_step(),
    .limiter_threshold(), .recovery_reference(), .left_one_delay_steps()
  );

  apc_host_model u_host (.ref_clk(ref_clk), .ser_csn(csn), .ser_cclk(cclk),
    .host_data(hd), .wire_data(sdw), .ser_data_oe_n(oe_n));

  task automatic cmp(input string what, input logic [47:0] e, input logic [47:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic go(input logic [15:0] fr, output logic [7:0] d, output logic dv);
    u_host.half = $urandom_range(1) ? 11 : 6;
    u_host.xfer(fr, d, dv);
  endtask

  // shadow keeps only writable bits, so fixed-zero positions expect zero
  task automatic wr(input logic [4:0] a, input logic [7:0] v, input logic [1:0] ch = 2'b00);
    logic [7:0] d;
    logic       dv;
    go({ch, 1'b1, a, v}, d, dv);
    if (ch == 2'b00 && a >= 5'h01 && a <= 5'h0C) sh[a] = v & mk[a];
  endtask

  task automatic chk(input logic [4:0] a, input logic dv_e);
    logic [7:0] d;
    logic [7:0] e;
    logic       dv;
    e = (a >= 5'h01 && a <= 5'h0C) ? sh[a] : 8'h00;
    go({2'b00, 1'b0, a, 8'h00}, d, dv);
    cmp($sformatf("drive %h", a), 48'(dv_e), 48'(dv));
    if (dv_e) cmp($sformatf("reg %h", a), 48'(e), 48'(d));
  endtask

  // covers the unmapped offsets 00 and 1F around the map
  task automatic chk_all();
    for (int a = 0; a < 14; a++) chk(5'(a == 13 ? 31 : a), 1'b1);
  endtask

  task automatic chk_fields();
    cmp("fields", {sh[1][5:2], sh[1][1:0], sh[2][7:4], sh[3][3:0], sh[5][5:4], sh[7], sh[11],
        sh[9][7] ? sh[7] : sh[8], sh[12][7] ? 7'(sh[12][5:0]) + 7'd1 : 7'd0},
        {u_dut.pll_reference_select, u_dut.master_role, u_dut.pll_power_bit,
         u_dut.first_highpass_enable, u_dut.amp_gain_a, u_dut.left_sensitivity_trim,
         u_dut.lowpass_active, u_dut.second_highpass_active, u_dut.left_volume_eff,
         u_dut.recovery_reference, u_dut.right_volume_eff,
         u_dut.left_one_delay_steps});
    cmp("fields2", {sh[2][1:0], sh[3][7:6], sh[4], sh[9][5:0], sh[10][7:6]},
        {u_dut.right_input_type, u_dut.left_input_type, u_dut.interface_format,
         u_dut.slot_format, u_dut.bitclock_out_ratio, u_dut.right_sensitivity_trim,
         u_dut.fast_recovery_speed, u_dut.fast_recovery_atten, u_dut.volume_ramp_time,
         u_dut.recovery_wait, u_dut.level_control_enable,
         u_dut.four_channel_link});
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    logic [7:0] d;
    rst = 1'b1;
    pdn_n = 1'b1;
    pwr = 1'b0;
    sel = 2'd0;
    cnt = 0;
    fs_tick = 1'b0;
    src = 4'h0;
    void'($urandom(32'hF50A));
    sh = rv;
    repeat (2) @(posedge ref_clk);
    #1 rst = 1'b0;
    repeat (6) @(posedge ref_clk);
    chk(5'h07, 1'b0);
    cmp("mclk idle", 48'd0, 48'(mclk_hi));
    wr(5'h01, 8'h98);
    chk_all();
    chk_fields();
    repeat (4) begin
      for (int a = 1; a <= 12; a++) begin
        d = 8'($urandom) & mk[a];
        if (a == 1) d[7] = 1'b1;
        wr(5'(a), d);
      end
      chk_all();
      chk_fields();
    end
    // fixed-zero bits set on purpose, unmapped writes, foreign chip address
    for (int a = 0; a < 14; a++) wr(5'(a == 13 ? 31 : a), 8'hFF);
    wr(5'h11, 8'hFF);
    wr(5'h07, 8'h3C, 2'b01);
    chk_all();
    chk_fields();
    #1 pdn_n = 1'b0;
    repeat (8) @(posedge ref_clk);
    #1 pdn_n = 1'b1;
    repeat (6) @(posedge ref_clk);
    sh = rv;
    chk(5'h01, 1'b0);
    chk_fields();
    wr(5'h01, 8'h98);
    chk_all();
    for (int c = 0; c < 4; c++) begin
      sel = 2'(c);
      wr(5'h06, {2'(c), 4'b0001, 2'(c)});
      mclk_hi = 0;
      repeat (20) @(posedge ref_clk);
      cmp("mclk runs", 48'd1, 48'(mclk_hi > 0));
      sel = sel + 2'd1;
      repeat (6) @(posedge ref_clk);
      mclk_hi = 0;
      repeat (20) @(posedge ref_clk);
      cmp("mclk other source", 48'd0, 48'(mclk_hi));
      do @(posedge ref_clk); while (fs_tick !== 1'b1);
      #1 pwr = 1'b1;
      d = 8'h00;
      for (int i = 0; i < 200 && u_dut.left_adc_ready !== 1'b1; i++) begin
        @(posedge ref_clk);
        if (fs_tick === 1'b1) d++;
        #2;
      end
      cmp("init ticks", 48'(ilen[c]), 48'(d));
      #1 pwr = 1'b0;
      repeat (2) @(posedge ref_clk);
      #1 cmp("ready clears", 48'd0, 48'(u_dut.left_adc_ready));
    end
    results();
  end

  initial begin
    repeat (90000) @(posedge ref_clk);
    n_mismatch++;
    results();
  end
endmodule
